// >>> inc/rsm_pkg.sv
// Constants shared by the registered signed 8x8 multiplier design.
// Assumes nothing of its surroundings; imported whole by each module except the bus model.
package rsm_pkg;
  // Operand and product widths.
  localparam int OP_W = 8;
  localparam int PROD_W = 16;
  // Position of the fractional product sign inside the raw 16-bit product.
  localparam int FRAC_SIGN_BIT = 14;
  // Top bit of the seven magnitude bits that follow the sign in the
  // lower product word.
  localparam int LOW_MAG_MSB = 6;
  // Half of one unit of the upper word, added when rounding is asked for.
  localparam logic [15:0] ROUND_ADD = 16'h0040;
  localparam logic [15:0] NO_ADD = 16'h0000;
  // Most negative operand value, fractional minus one.
  localparam logic [7:0] MOST_NEG = 8'h80;
  // Reset values of the operand and product registers.
  localparam logic [7:0] OP_RESET = 8'h00;
  localparam logic [7:0] WORD_RESET = 8'h00;
endpackage

// >>> src/rsm_array.sv
// Combinational signed multiplier array with rounding and word formatting.
// Assumes operands come from registers; it holds no clocked state itself.
`timescale 1ns/1ps
`default_nettype none
module rsm_array
  import rsm_pkg::*;
(
  // Operands and round control
  input wire logic [7:0] xOp,
  input wire logic [7:0] yOp,
  input wire logic roundEn,
  // Formatted product words
  output logic [7:0] upperWord,
  output logic [7:0] lowerWord
);
  logic signed [15:0] fullProd;
  logic [15:0] sumProd;

  // Full-precision signed product, no bits dropped.
  assign fullProd = $signed(xOp) * $signed(yOp);

  // Rounding adds half an upper-word unit before the register stage.
  // The largest product plus that half still fits, so no carry escapes.
  assign sumProd = fullProd +
    (roundEn ? ROUND_ADD : NO_ADD);

  // Fractional layout: bit 15 duplicates the sign except for -1 x -1,
  // where dropping it yields -1 instead of an unrepresentable +1.
  assign upperWord = sumProd[FRAC_SIGN_BIT -: OP_W];
  // The lower word repeats the sign in its top bit.
  assign lowerWord = {sumProd[FRAC_SIGN_BIT], sumProd[LOW_MAG_MSB:0]};
endmodule
`default_nettype wire

// >>> src/rsm_multiplier.sv
// Registered signed 8x8 multiplier: operand registers, round control,
// combinational array and a two-byte product register with float controls.
// Assumes operand clocks and float controls are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module rsm_multiplier
  import rsm_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Operand inputs and their load clocks
  input wire logic [7:0] xOperand,
  input wire logic [7:0] yOperand,
  input wire logic xOperandClock,
  input wire logic yOperandClock,
  input wire logic roundRequest,
  // Product register load clock and float controls
  input wire logic productClock,
  input wire logic upperOutputFloat,
  input wire logic lowerOutputFloat,
  // Upper product byte pin
  output logic [7:0] upperProductByte,
  output logic upperProductOe,
  // Lower product byte pin
  output logic [7:0] lowerProductByte,
  output logic lowerProductOe
);
  logic xClkPrev;
  logic yClkPrev;
  logic orClkPrev;
  logic pClkPrev;
  logic xRise;
  logic yRise;
  logic orRise;
  logic pRise;
  logic [7:0] xReg;
  logic [7:0] yReg;
  logic roundReg;
  logic [7:0] next_upper;
  logic [7:0] next_lower;

  // The device clocks arrive as levels sampled by clk; a rise is seen
  // when the level goes from low to high between two samples.
  // History freezes with the enable: a clock that rose while frozen and is
  // still high is taken once the enable returns, one that also fell is lost.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xClkPrev <= 1'b0;
      yClkPrev <= 1'b0;
      orClkPrev <= 1'b0;
    end else if (ce) begin
      xClkPrev <= xOperandClock;
      yClkPrev <= yOperandClock;
      orClkPrev <= xOperandClock | yOperandClock;
    end
  end

  // Product clock history, kept apart from the operand side.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pClkPrev <= 1'b0;
    end else if (ce) begin
      pClkPrev <= productClock;
    end
  end

  assign xRise = ce & xOperandClock & ~xClkPrev;
  assign yRise = ce & yOperandClock & ~yClkPrev;
  // A normally high clock hides the other clock's rise; hosts keep both low.
  assign orRise = ce & (xOperandClock | yOperandClock)
    & ~orClkPrev;
  assign pRise = ce & productClock & ~pClkPrev;

  // X operand register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xReg <= OP_RESET;
    end else if (xRise) begin
      xReg <= xOperand;
    end
  end

  // Y operand register, independent of X.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      yReg <= OP_RESET;
    end else if (yRise) begin
      yReg <= yOperand;
    end
  end

  // Round control travels with the operands.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      roundReg <= 1'b0;
    end else if (orRise) begin
      roundReg <= roundRequest;
    end
  end

  rsm_array uArray (
    .xOp(xReg),
    .yOp(yReg),
    .roundEn(roundReg),
    .upperWord(next_upper),
    .lowerWord(next_lower)
  );

  // Both bytes load together on the product clock.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      upperProductByte <= WORD_RESET;
      lowerProductByte <= WORD_RESET;
    end else if (pRise) begin
      upperProductByte <= next_upper;
      lowerProductByte <= next_lower;
    end
  end

  // Each byte drives only while its float control is low.
  assign upperProductOe = ~upperOutputFloat;
  assign lowerProductOe = ~lowerOutputFloat;

  // Checks on the device's own behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  logic signed [15:0] expProd;
  logic [15:0] expRound;
  assign expProd = $signed(xReg) * $signed(yReg);
  assign expRound = expProd + ROUND_ADD;

  // Expected words, named so that past values are taken of plain signals.
  logic [FRAC_SIGN_BIT:0] expFrac;
  logic [7:0] expRndUpper;
  logic [7:0] expRndLower;
  logic [7:0] expPlainLower;
  logic expSign;
  assign expFrac = expProd[FRAC_SIGN_BIT:0];
  assign expRndUpper = expRound[FRAC_SIGN_BIT -: OP_W];
  assign expRndLower = {expRound[FRAC_SIGN_BIT], expRound[LOW_MAG_MSB:0]};
  assign expPlainLower = {expProd[FRAC_SIGN_BIT], expProd[LOW_MAG_MSB:0]};
  // Rounding can carry a tiny negative product up to zero, so the sign
  // that the words must carry is taken after the round step.
  assign expSign = roundReg ? expRound[FRAC_SIGN_BIT]
    : expProd[FRAC_SIGN_BIT];

  // One product load with a captured round request, one without.
  sequence seqRoundArm;
    pRise && roundReg;
  endsequence

  sequence seqPlainArm;
    pRise && !roundReg;
  endsequence

  chk_x_load: assert property (xRise |=> xReg == $past(xOperand))
    else $error("X register did not capture operand on its clock rise");
  chk_y_load: assert property (yRise |=> yReg == $past(yOperand))
    else $error("Y register did not capture operand on its clock rise");
  chk_x_hold: assert property (!xRise |=> $stable(xReg))
    else $error("X register changed without its clock rise");
  chk_round_cap: assert property (
      orRise |=> roundReg == $past(roundRequest))
    else $error("Round request not captured on operand clock OR rise");
  chk_full_prod: assert property (pRise && !roundReg &&
      !(xReg == MOST_NEG && yReg == MOST_NEG)
      |=> $signed({upperProductByte, lowerProductByte[LOW_MAG_MSB:0]})
      == $past(expFrac))
    else $error("Registered product differs from signed product");
  chk_minus_one: assert property (pRise && !roundReg &&
      xReg == MOST_NEG && yReg == MOST_NEG
      |=> upperProductByte == MOST_NEG && lowerProductByte == MOST_NEG)
    else $error("Minus one squared did not give minus one");
  chk_sign_both: assert property (
      upperProductByte[OP_W-1] == lowerProductByte[OP_W-1])
    else $error("Product sign differs between upper and lower bytes");
  chk_round_add: assert property (seqRoundArm |=>
      upperProductByte == $past(expRndUpper))
    else $error("Rounded upper byte is wrong");
  chk_prod_hold: assert property (!pRise |=>
      $stable(upperProductByte) && $stable(lowerProductByte))
    else $error("Product register changed without product clock rise");
  chk_float_ctl: assert property (
      upperOutputFloat != $past(upperOutputFloat)
      |-> upperProductOe == !upperOutputFloat
      && lowerProductOe == !lowerOutputFloat)
    else $error("Output enable does not follow float control");

  chk_lower_float: assert property (
      lowerOutputFloat != $past(lowerOutputFloat)
      |-> lowerProductOe == !lowerOutputFloat)
    else $error("Lower output enable does not follow its float control");

  // Register holds, the lower product byte and the sign bit of both product bytes.
  chk_y_hold: assert property (!yRise |=> $stable(yReg))
    else $error("Y register changed without its clock rise");
  chk_round_hold: assert property (!orRise |=> $stable(roundReg))
    else $error("Round control changed without an operand clock rise");
  chk_round_low: assert property (seqRoundArm |=>
      lowerProductByte == $past(expRndLower))
    else $error("Rounded lower byte is wrong");
  chk_plain_low: assert property (seqPlainArm |=>
      lowerProductByte == $past(expPlainLower))
    else $error("Unrounded lower byte is wrong");
  chk_prod_sign: assert property (pRise |=>
      upperProductByte[OP_W-1] == $past(expSign)
      && lowerProductByte[OP_W-1] == $past(expSign))
    else $error("Product sign bit is wrong in a product byte");

  // A low enable freezes every register, whatever the device clocks do.
  chk_ce_freeze: assert property (!ce |=> $stable(xReg) &&
      $stable(yReg) && $stable(roundReg)
      && $stable(upperProductByte) && $stable(lowerProductByte))
    else $error("A register changed while the clock enable was low");
endmodule
`default_nettype wire

// >>> dv/rsm_bus_model.sv
// Host-side shared 8-bit bus onto which both product bytes are multiplexed.
// Assumes the host enables at most one product byte pin at a time.
`timescale 1ns/1ps
`default_nettype none
module rsm_bus_model (
  // Product pins
  input wire logic [7:0] upperByte,
  input wire logic upperOe,
  input wire logic [7:0] lowerByte,
  input wire logic lowerOe,
  // Resolved bus
  output logic [7:0] busLines
);
  logic [7:0] lastSeen = 8'h00;
  always @* begin
    if (upperOe && !lowerOe) lastSeen = upperByte;
    else if (lowerOe && !upperOe) lastSeen = lowerByte;
  end
  // An idle bus shows the inverse of its last value, so stale data fails.
  assign busLines = (upperOe ^ lowerOe) ? lastSeen : ~lastSeen;
endmodule
`default_nettype wire

// >>> dv/rsm_multiplier_bench.sv
// Self-checking bench for the registered signed multiplier.
// Assumes the bench plays the host and reads results over a shared bus.
`timescale 1ns/1ps
`default_nettype none
module rsm_multiplier_bench;
  import rsm_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] xOperand = 8'h00;
  logic [7:0] yOperand = 8'h00;
  logic xOperandClock = 1'b0;
  logic yOperandClock = 1'b0;
  logic roundRequest = 1'b0;
  logic productClock = 1'b0;
  logic upperOutputFloat = 1'b1;
  logic lowerOutputFloat = 1'b1;
  logic [7:0] upperProductByte, lowerProductByte, busLines;
  logic upperProductOe, lowerProductOe;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [16:0] table_c [6] = '{17'h0_4040, 17'h0_8080, 17'h0_7F80,
    17'h1_3527, 17'h1_807F, 17'h0_FF01};
  always #25 clk = ~clk;
  rsm_multiplier u_dut (.clk(clk), .rstn(rstn), .ce(ce),
    .xOperand(xOperand), .yOperand(yOperand), .xOperandClock(xOperandClock),
    .yOperandClock(yOperandClock), .roundRequest(roundRequest),
    .productClock(productClock), .upperOutputFloat(upperOutputFloat),
    .lowerOutputFloat(lowerOutputFloat), .upperProductByte(upperProductByte),
    .upperProductOe(upperProductOe), .lowerProductByte(lowerProductByte),
    .lowerProductOe(lowerProductOe));
  rsm_bus_model u_bus (.upperByte(upperProductByte), .upperOe(upperProductOe),
    .lowerByte(lowerProductByte), .lowerOe(lowerProductOe),
    .busLines(busLines));
  function automatic logic [15:0] want(input logic [7:0] x, y, input logic r);
    logic signed [15:0] p;
    p = $signed(x) * $signed(y);
    p = p + {9'h000, r, 6'h00};
    return {p[14:7], p[14], p[6:0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Sel 0 loads X, 1 loads Y, 2 loads the product register.
  task automatic load(input int sel, input logic [7:0] v, input logic r);
    @(posedge clk);
    roundRequest <= r;
    if (sel == 0) begin
      xOperand <= v;
      xOperandClock <= 1'b1;
    end else if (sel == 1) begin
      yOperand <= v;
      yOperandClock <= 1'b1;
    end else productClock <= 1'b1;
    @(posedge clk);
    {xOperandClock, yOperandClock, productClock} <= 3'h0;
    @(posedge clk);
  endtask
  task automatic readout(input logic [15:0] exp);
    @(posedge clk);
    {upperOutputFloat, lowerOutputFloat} <= 2'h1;
    @(negedge clk);
    check(busLines, exp[15:8]);
    check({7'h00, lowerProductOe}, 8'h00);
    @(posedge clk);
    {upperOutputFloat, lowerOutputFloat} <= 2'h2;
    @(negedge clk);
    check(busLines, exp[7:0]);
    check({7'h00, upperProductOe}, 8'h00);
    @(posedge clk);
    {upperOutputFloat, lowerOutputFloat} <= 2'h3;
    @(negedge clk);
    check({6'h00, upperProductOe, lowerProductOe}, 8'h00);
  endtask
  task automatic t_table();
    for (int i = 0; i < 6; i++) begin
      load(0, table_c[i][15:8], table_c[i][16]);
      load(1, table_c[i][7:0], table_c[i][16]);
      load(2, 8'h00, 1'b0);
      // Covers signed, minus one squared and rounded cases.
      readout(want(table_c[i][15:8], table_c[i][7:0],
        table_c[i][16]));
    end
  endtask
  task automatic t_constant();
    load(1, 8'h03, 1'b0);
    load(0, 8'h05, 1'b0);
    load(2, 8'h00, 1'b0);
    readout(want(8'h05, 8'h03, 1'b0));
    load(0, 8'hFB, 1'b0);
    load(2, 8'h00, 1'b0);
    readout(want(8'hFB, 8'h03, 1'b0));
  endtask
  task automatic t_hold();
    @(posedge clk);
    xOperand <= 8'h11;
    yOperand <= 8'h22;
    load(2, 8'h00, 1'b0);
    readout(want(8'hFB, 8'h03, 1'b0));
  endtask
  // Clock pulses that come and go while the enable is low are lost, so
  // neither the X register nor the product register may move.
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    load(0, 8'h7F, 1'b1);
    load(2, 8'h00, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    readout(want(8'hFB, 8'h03, 1'b0));
    load(2, 8'h00, 1'b0);
    readout(want(8'hFB, 8'h03, 1'b0));
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // A hang is cut short well beyond the roughly 120 cycles the run needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_table();
    t_constant();
    t_hold();
    t_freeze();
    end_of_test();
  end
endmodule
`default_nettype wire
